// File: rtl/ptt_defines.svh
// offsets, field positions, reset values for pace threshold and test tone registers
`ifndef PTT_DEFINES_SVH
`define PTT_DEFINES_SVH
`define PTT_ADDR_PACE_TH   6'h07
`define PTT_ADDR_TONE      6'h08
`define PTT_PACE_TH_RST    24'h242424
`define PTT_TONE_RST       24'h000000
`define PTT_PACE_FIELD_RST 8'h24
`define PTT_TONE_SEL_RST   5'h00
`define PTT_WAVE_RST       2'h0
`define PTT_TONE_BIT_RST   1'h0
`define PTT_TONE_SEL_HI    23
`define PTT_TONE_SEL_LO    19
`define PTT_WAVE_HI        4
`define PTT_WAVE_LO        3
`define PTT_BIT_INTERNAL   2
`define PTT_BIT_PIN_OUT    1
`define PTT_BIT_ENABLE     0
`define PTT_TONE_WMASK     24'hf8001f
`endif

// File: rtl/ptt_pkg.sv
// types for the pace threshold and test tone register bank
package ptt_pkg;
  typedef enum logic [1:0] {
    PTT_WAVE_SINE_10HZ  = 2'h0,
    PTT_WAVE_SINE_150HZ = 2'h1,
    PTT_WAVE_SQUARE_1HZ = 2'h2
  } ptt_wave_t;

  typedef struct packed {
    logic [4:0] electrode_tone;
    logic       channels_internal;
    logic       pin_tone_connect;
    logic       slave_dac_off;
    logic       chain_tone_on;
    logic       ac_leadoff_force_off;
    ptt_wave_t  wave;
  } ptt_route_t;
endpackage

// File: rtl/ptt_regs.sv
// pace threshold and test tone configuration registers with tone routing decode
`timescale 1ns/1ps
`include "ptt_defines.svh"

// Summary of operation
// - 24-bit RW pace threshold register, three 8-bit lead fields, each reset 0x24.
// - pace threshold register exists only on the full-featured variant.
// - 24-bit RW test tone register at 0x08, resets to zero, tone off.
// - bits 23..19 pick reference (0) or tone/unconnected (1) per electrode.
// - bits 4..3 pick 10 Hz sine, 150 Hz sine, or 1 Hz square.
// - bit 2 routes tone to pin externally or internally to all channels.
// - internal routing on a gang slave keeps pin connected and disables its DAC.
// - bit 1 connects tone to calibration pin, only with internal routing.
// - bit 0 enables tone through the whole signal chain.
// - tone enable forces ac lead-off detection off.
// - calibration mode overrides the test tone.
module ptt_regs #(
  parameter bit HAS_PACE = 1'b1
) (
  input  wire logic               CLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               WR_EN_IN,
  input  wire logic [5:0]         ADDR_IN,
  input  wire logic [23:0]        WDATA_IN,
  input  wire logic               CAL_MODE_IN,
  input  wire logic               SLAVE_IN,
  output logic      [23:0]        RDATA_OUT,
  output logic      [23:0]        PACE_TH_OUT,
  output ptt_pkg::ptt_route_t     ROUTE_OUT
);
  localparam int unsigned LEADS      = 3;
  localparam int unsigned LEAD_W     = 8;
  localparam int unsigned ELECTRODES = 5;

  logic                       sel_pace;
  logic                       sel_tone;
  logic                       wr_tone;
  wire logic [23:0]           pace_th_word;

  logic [ELECTRODES-1:0]      electrode_sel_r;
  logic [1:0]                 wave_code_r;
  logic                       internal_r;
  logic                       pin_out_r;
  logic                       enable_r;
  logic [23:0]                tone_word;

  logic                       cal_mode_s1_r;
  logic                       cal_mode_r;
  logic                       slave_s1_r;
  logic                       slave_r;

  logic [23:0]                rdata_nxt;
  logic                       tone_active;
  wire logic [ELECTRODES-1:0] electrode_tone_nxt;
  ptt_pkg::ptt_wave_t         wave_nxt;
  logic                       pin_connect_nxt;
  logic                       slave_dac_off_nxt;
  ptt_pkg::ptt_route_t        route_nxt;

  // calibration mode is a level from another domain
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cal_mode_s1_r <= 1'b0;
      cal_mode_r    <= 1'b0;
    end else begin
      cal_mode_s1_r <= CAL_MODE_IN;
      cal_mode_r    <= cal_mode_s1_r;
    end
  end

  // gang role strap, also from outside this clock
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      slave_s1_r <= 1'b0;
      slave_r    <= 1'b0;
    end else begin
      slave_s1_r <= SLAVE_IN;
      slave_r    <= slave_s1_r;
    end
  end

  assign sel_pace = (ADDR_IN == `PTT_ADDR_PACE_TH);
  assign sel_tone = (ADDR_IN == `PTT_ADDR_TONE);
  assign wr_tone  = WR_EN_IN & sel_tone;

  // reduced variants carry no threshold storage at all
  generate
    if (HAS_PACE) begin : g_pace
      logic wr_pace;
      assign wr_pace = WR_EN_IN & sel_pace;
      for (genvar k = 0; k < LEADS; k++) begin : g_lead
        logic [LEAD_W-1:0] th_r;
        always_ff @(posedge CLK_IN or posedge RST_IN) begin
          if (RST_IN) begin
            th_r <= `PTT_PACE_FIELD_RST;
          end else if (wr_pace) begin
            th_r <= WDATA_IN[k*LEAD_W +: LEAD_W];
          end
        end
        assign pace_th_word[k*LEAD_W +: LEAD_W] = th_r;
      end
    end else begin : g_no_pace
      assign pace_th_word = 24'h000000;
    end
  endgenerate

  // reserved bits 18..5 have no storage, so stray writes cannot stick
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      electrode_sel_r <= `PTT_TONE_SEL_RST;
    end else if (wr_tone) begin
      electrode_sel_r <= WDATA_IN[`PTT_TONE_SEL_HI:`PTT_TONE_SEL_LO];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wave_code_r <= `PTT_WAVE_RST;
    end else if (wr_tone) begin
      wave_code_r <= WDATA_IN[`PTT_WAVE_HI:`PTT_WAVE_LO];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      internal_r <= `PTT_TONE_BIT_RST;
    end else if (wr_tone) begin
      internal_r <= WDATA_IN[`PTT_BIT_INTERNAL];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_out_r <= `PTT_TONE_BIT_RST;
    end else if (wr_tone) begin
      pin_out_r <= WDATA_IN[`PTT_BIT_PIN_OUT];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      enable_r <= `PTT_TONE_BIT_RST;
    end else if (wr_tone) begin
      enable_r <= WDATA_IN[`PTT_BIT_ENABLE];
    end
  end

  always_comb begin
    tone_word                                    = `PTT_TONE_RST;
    tone_word[`PTT_TONE_SEL_HI:`PTT_TONE_SEL_LO] = electrode_sel_r;
    tone_word[`PTT_WAVE_HI:`PTT_WAVE_LO]         = wave_code_r;
    tone_word[`PTT_BIT_INTERNAL]                 = internal_r;
    tone_word[`PTT_BIT_PIN_OUT]                  = pin_out_r;
    tone_word[`PTT_BIT_ENABLE]                   = enable_r;
  end

  always_comb begin
    rdata_nxt = 24'h000000;
    if (sel_pace) begin
      rdata_nxt = pace_th_word;
    end else if (sel_tone) begin
      rdata_nxt = tone_word;
    end
  end

  // calibration owns the channels, so the tone is fully withheld
  assign tone_active = enable_r & ~cal_mode_r;

  // external routing leaves a selected input unconnected
  for (genvar e = 0; e < ELECTRODES; e++) begin : g_electrode
    assign electrode_tone_nxt[e] = tone_active & electrode_sel_r[e];
  end

  // code 11 folds onto the square wave, as does code 10
  always_comb begin
    if (wave_code_r[1]) begin
      wave_nxt = ptt_pkg::PTT_WAVE_SQUARE_1HZ;
    end else if (wave_code_r[0]) begin
      wave_nxt = ptt_pkg::PTT_WAVE_SINE_150HZ;
    end else begin
      wave_nxt = ptt_pkg::PTT_WAVE_SINE_10HZ;
    end
  end

  // a slave keeps the pin so the master's tone reaches it
  always_comb begin
    pin_connect_nxt   = 1'b0;
    slave_dac_off_nxt = 1'b0;
    if (tone_active) begin
      if (internal_r) begin
        pin_connect_nxt   = pin_out_r | slave_r;
        slave_dac_off_nxt = slave_r;
      end else begin
        pin_connect_nxt   = 1'b1;
      end
    end
  end

  always_comb begin
    route_nxt                      = '0;
    route_nxt.electrode_tone       = electrode_tone_nxt;
    route_nxt.channels_internal    = tone_active & internal_r;
    route_nxt.pin_tone_connect     = pin_connect_nxt;
    route_nxt.slave_dac_off        = slave_dac_off_nxt;
    route_nxt.chain_tone_on        = tone_active;
    route_nxt.ac_leadoff_force_off = enable_r;
    route_nxt.wave                 = wave_nxt;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 24'h000000;
    end else begin
      RDATA_OUT <= rdata_nxt;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PACE_TH_OUT <= HAS_PACE ? `PTT_PACE_TH_RST : 24'h000000;
    end else begin
      PACE_TH_OUT <= pace_th_word;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ROUTE_OUT <= '0;
    end else begin
      ROUTE_OUT <= route_nxt;
    end
  end
endmodule

// File: verif/ptt_regs_sva.sv
// assertions on the pace threshold and test tone register ports
`timescale 1ns/1ps
module ptt_regs_sva (
  input wire logic                CLK_IN,
  input wire logic                RST_IN,
  input wire logic                WR_EN_IN,
  input wire logic                CAL_MODE_IN,
  input wire logic [5:0]          ADDR_IN,
  input wire logic [23:0]         WDATA_IN,
  input wire logic [23:0]         RDATA_OUT,
  input wire logic [23:0]         PACE_TH_OUT,
  input wire ptt_pkg::ptt_route_t ROUTE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // six quiet cycles cover read, sync and output latency
  sequence quiet; (ADDR_IN == 8 && !WR_EN_IN && !CAL_MODE_IN)[*6]; endsequence
  chk_pace_write:
    assert property (WR_EN_IN && ADDR_IN == 7 ##1 !WR_EN_IN[*3] |-> PACE_TH_OUT == $past(WDATA_IN, 3))
      else $error("pace out");
  chk_pace_read:
    assert property ((ADDR_IN == 7 && !WR_EN_IN)[*4] |-> RDATA_OUT == PACE_TH_OUT) else $error("pace read");
  chk_tone_rsvd:
    assert property (ADDR_IN == 8 |=> RDATA_OUT[18:5] == 14'h0) else $error("reserved bits");
  chk_leadoff_off:
    assert property ((ADDR_IN == 8 && !WR_EN_IN)[*6] |-> ROUTE_OUT.ac_leadoff_force_off == RDATA_OUT[0])
      else $error("leadoff");
  chk_chain_on:
    assert property (quiet |-> ROUTE_OUT.chain_tone_on == RDATA_OUT[0]) else $error("chain tone");
  chk_cal_prio:
    assert property (CAL_MODE_IN[*6] |-> !ROUTE_OUT.chain_tone_on) else $error("cal priority");
  chk_wave_route:
    assert property (quiet ##0 RDATA_OUT[0] |-> ROUTE_OUT.wave == (RDATA_OUT[4] ? 2'h2 : RDATA_OUT[4:3])
      && ROUTE_OUT.channels_internal == RDATA_OUT[2]) else $error("wave or routing");
  chk_electrode_sel:
    assert property (quiet ##0 RDATA_OUT[0] |-> ROUTE_OUT.electrode_tone == RDATA_OUT[23:19]) else $error("electrodes");
  chk_slave_dac:
    assert property (ROUTE_OUT.slave_dac_off |-> ROUTE_OUT.channels_internal && ROUTE_OUT.pin_tone_connect)
      else $error("slave dac");
  chk_ext_pin:
    assert property (ROUTE_OUT.chain_tone_on && !ROUTE_OUT.channels_internal |-> ROUTE_OUT.pin_tone_connect)
      else $error("external pin");
  cover property (ROUTE_OUT.slave_dac_off);
  cover property (WR_EN_IN && ADDR_IN == 8);
  cover property (CAL_MODE_IN[*6]);
  cover property (quiet ##0 RDATA_OUT[4]);
endmodule
bind ptt_regs ptt_regs_sva chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .WR_EN_IN(WR_EN_IN), .CAL_MODE_IN(CAL_MODE_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT), .PACE_TH_OUT(PACE_TH_OUT), .ROUTE_OUT(ROUTE_OUT));

// File: verif/pace_threshold_test_tone_regs_tb.sv
// self-checking bench for the pace threshold and test tone registers
`timescale 1ns/1ps
module pace_threshold_test_tone_regs_tb;
  logic CLK_IN = 0, RST_IN = 1, WR_EN_IN = 0, CAL_MODE_IN = 0, SLAVE_IN = 0;
  logic [5:0] ADDR_IN = 0;
  logic [23:0] WDATA_IN = 0, RDATA_OUT, PACE_TH_OUT, d, tone_m = 24'h000000, pace_m = 24'h242424;
  ptt_pkg::ptt_route_t ROUTE_OUT;
  int mismatches = 0, samples_checked = 0, seed = 49, i;
  always #5 CLK_IN = ~CLK_IN;
  ptt_regs dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .WR_EN_IN(WR_EN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .CAL_MODE_IN(CAL_MODE_IN), .SLAVE_IN(SLAVE_IN), .RDATA_OUT(RDATA_OUT), .PACE_TH_OUT(PACE_TH_OUT), .ROUTE_OUT(ROUTE_OUT));
  task automatic cmp_rdata(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pace(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t thresholds got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_route(input ptt_pkg::ptt_route_t got, input ptt_pkg::ptt_route_t exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t route got %h exp %h", $time, got, exp);
    end
  endtask
  // reference routing model, built from the register word, calibration mode and slave strap
  function automatic ptt_pkg::ptt_route_t exp_route(input logic [23:0] t, input logic cal, input logic slv);
    ptt_pkg::ptt_route_t r;
    r = '0;
    r.wave = t[4] ? ptt_pkg::PTT_WAVE_SQUARE_1HZ : ptt_pkg::ptt_wave_t'({1'b0, t[3]});
    r.ac_leadoff_force_off = t[0];
    if (t[0] && !cal) begin
      r.chain_tone_on     = 1'b1;
      r.electrode_tone    = t[23:19];
      r.channels_internal = t[2];
      r.pin_tone_connect  = !t[2] || t[1] || slv;
      r.slave_dac_off     = t[2] && slv;
    end
    return r;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [23:0] v);
    @(negedge CLK_IN);
    {WR_EN_IN, ADDR_IN, WDATA_IN} = {1'b1, a, v};
    @(negedge CLK_IN);
    WR_EN_IN = 0;
    if (a == 6'h07) pace_m = v;
    if (a == 6'h08) tone_m = v;
  endtask
  // long settle lets route outputs and synced inputs follow too
  task automatic rd(input logic [5:0] a);
    ADDR_IN = a;
    repeat (6) @(negedge CLK_IN);
    cmp_rdata(RDATA_OUT, (a == 6'h07) ? pace_m : (a == 6'h08) ? tone_m : 24'h000000);
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge CLK_IN);
    RST_IN = 0;
    rd(6'h07);
    cmp_pace(PACE_TH_OUT, pace_m);
    rd(6'h08);
    cmp_route(ROUTE_OUT, exp_route(tone_m, 1'b0, 1'b0));
    d = 24'($random(seed));
    wr(6'h07, d);
    rd(6'h07);
    cmp_pace(PACE_TH_OUT, pace_m);
    wr(6'h09, ~d);
    rd(6'h09);
    rd(6'h07);
    cmp_pace(PACE_TH_OUT, pace_m);
    $display("test pace done");
    for (i = 0; i < 6; i++) begin
      d = 24'($random(seed));
      SLAVE_IN = i[0];
      wr(6'h08, {d[23:19], 14'h0000, i[1:0], i[1] ^ i[0], d[1], i != 4});
      repeat (4) @(negedge CLK_IN);
      rd(6'h08);
      cmp_route(ROUTE_OUT, exp_route(tone_m, 1'b0, SLAVE_IN));
    end
    $display("test tone done");
    CAL_MODE_IN = 1;
    rd(6'h08);
    cmp_route(ROUTE_OUT, exp_route(tone_m, 1'b1, SLAVE_IN));
    $display("test calibration done");
    final_report;
  end
endmodule
